// ===== rtl/sps_pkg.sv
// Package with state encodings, input indices, fast latch reset levels and synchroniser depth for the start-up protection sequencer.
// Functional notes
// - Below trip select low charge current; above trip raised current until lockout level.
// - Between lockout and start-up thresholds the charge current returns to low.
// - Passing start-up threshold enables internal circuitry and stops high-voltage charge current.
// - After start-up enable protection-input source, both soft-starts and compensation clamp.
// - Correction stage runs only with protection input, compensation level and soft-start done.
// - Flyback stage runs once its current-sense soft-start is charged.
// - Protection input low when supply reaches lockout: deactivate, charge current on again.
// - Feedback reaching timeout level after flyback start flags error and safe restart.
// - Any protection stops both converters and lets the supply fall to lockout; after a latched fault the code recharges once below start-up.
// - Latched protection recharges supply but keeps both converters stopped.
// - Safe-restart protection recharges supply then runs start-up again.
// - Correction overvoltage inhibits correction switching until the voltage falls again.
// - Mains below stop level halts correction switching until above the start level.
// - Supply below lockout stops both, disables drivers, recharges from high-voltage pin.
// - Latched protection clears when mains drops below 750 mV then rises to 870 mV.
// - Overtemperature is latched, blocks supply recharge, cleared only by fast latch reset; the code blocks recharge only in SPS_LATCHED.
package sps_pkg;
    // Comparator input indices.
    localparam int IDX_TRIP = 0;
    localparam int IDX_LOCKOUT = 1;
    localparam int IDX_STARTUP = 2;
    localparam int IDX_LATCH_EN = 3;
    localparam int IDX_COMP_EN = 4;
    localparam int IDX_PFC_SS = 5;
    localparam int IDX_FB_SS = 6;
    localparam int IDX_FB_TIMEOUT = 7;
    localparam int IDX_OVP = 8;
    localparam int IDX_MAINS_STOP = 9;
    localparam int IDX_MAINS_START = 10;
    localparam int IDX_RESET_LOW = 11;
    localparam int IDX_RESET_HIGH = 12;
    localparam int IDX_OTP = 13;
    localparam int IDX_SAFE_FAULT = 14;
    localparam int IDX_LATCH_FAULT = 15;
    localparam int NUM_INPUTS = 16;
    // Fast latch reset levels, in millivolts, held for reference only; no logic in the project uses them.
    localparam int RESET_LOW_MV = 750;
    localparam int RESET_HIGH_MV = 870;
    // Synchroniser depth.
    localparam int SYNC_STAGES = 2;
    typedef enum logic [2:0] {
        SPS_CHARGE,
        SPS_ARMED,
        SPS_RUN,
        SPS_DISCHARGE,
        SPS_LATCHED
    } sps_state_e;
endpackage : sps_pkg

// ===== rtl/sps_sync.sv
// Two-stage synchroniser bank for the comparator results.
`timescale 1ns/1ns
module sps_sync #(
    parameter int WIDTH = sps_pkg::NUM_INPUTS
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_enable,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } sps_sync_s;

    sps_sync_s state_ff;
    sps_sync_s nxt_state;

    // A bank of zero width cannot be built, so elaboration stops here.
    if (WIDTH < 1) begin : g_width_check
        $error("sps_sync needs at least one input");
    end

    always_comb begin
        nxt_state = state_ff;
        if (i_enable) begin
            nxt_state.meta = i_async;
            nxt_state.sync = state_ff.meta;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign o_sync = state_ff.sync;
endmodule : sps_sync

// ===== rtl/sps_sequencer.sv
// Start-up, lockout and protection sequencer with Avalon-MM status, mask and control registers.
`timescale 1ns/1ns
module sps_sequencer (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_clock_enable,
    input wire logic i_supply_above_trip,
    input wire logic i_supply_above_lockout,
    input wire logic i_supply_above_startup,
    input wire logic i_latch_above_enable,
    input wire logic i_compensation_at_enable,
    input wire logic i_correction_softstart_done,
    input wire logic i_flyback_softstart_done,
    input wire logic i_feedback_at_timeout,
    input wire logic i_correction_overvoltage,
    input wire logic i_mains_below_stop,
    input wire logic i_mains_above_start,
    input wire logic i_mains_below_reset_low,
    input wire logic i_mains_above_reset_high,
    input wire logic i_overtemperature,
    input wire logic i_safe_restart_fault,
    input wire logic i_latched_fault,
    input wire logic [1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic o_charge_on,
    output logic o_charge_high,
    output logic o_internal_enable,
    output logic o_latch_source_on,
    output logic o_softstart_charge,
    output logic o_compensation_clamp,
    output logic o_correction_drive_en,
    output logic o_flyback_drive_en,
    output logic o_irq
);
    localparam logic [1:0] ADDR_STATUS = 2'h0;
    localparam logic [1:0] ADDR_MASK = 2'h1;
    localparam logic [1:0] ADDR_STATE = 2'h2;
    localparam logic [1:0] ADDR_CONTROL = 2'h3;
    // Status bits.
    localparam int EV_TIMEOUT = 0;
    localparam int EV_LOCKOUT = 1;
    localparam int EV_LATCHED = 2;
    localparam int EV_RUN = 3;
    localparam int EV_W = 4;

    typedef struct packed {
        sps_pkg::sps_state_e st;
        logic fb_running;
        logic mains_ok;
        logic reset_seen_low;
        logic otp_latched;
        logic [EV_W-1:0] status;
        logic [EV_W-1:0] mask;
        logic force_stop;
        logic ack;
        logic [31:0] rdata;
    } sps_seq_s;

    sps_seq_s state_ff;
    sps_seq_s nxt_state;
    logic [sps_pkg::NUM_INPUTS-1:0] raw;
    logic [sps_pkg::NUM_INPUTS-1:0] s;
    logic [EV_W-1:0] events;

    assign raw = {i_latched_fault, i_safe_restart_fault, i_overtemperature, i_mains_above_reset_high,
                  i_mains_below_reset_low, i_mains_above_start, i_mains_below_stop, i_correction_overvoltage,
                  i_feedback_at_timeout, i_flyback_softstart_done, i_correction_softstart_done,
                  i_compensation_at_enable, i_latch_above_enable, i_supply_above_startup,
                  i_supply_above_lockout, i_supply_above_trip};

    sps_sync #(.WIDTH(sps_pkg::NUM_INPUTS)) u_sync (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_enable(i_clock_enable),
        .i_async(raw),
        .o_sync(s)
    );

    function automatic logic [31:0] reg_read(input logic [1:0] a, input sps_seq_s q);
        reg_read = 32'h0;
        unique case (a)
            ADDR_STATUS: reg_read = {28'h0, q.status};
            ADDR_MASK: reg_read = {28'h0, q.mask};
            ADDR_STATE: reg_read = {24'h0, q.otp_latched, q.mains_ok, q.fb_running, 2'h0, q.st};
            ADDR_CONTROL: reg_read = {31'h0, q.force_stop};
        endcase
    endfunction : reg_read

    always_comb begin
        nxt_state = state_ff;
        events = '0;
        nxt_state.ack = 1'b0;
        if (s[sps_pkg::IDX_MAINS_STOP]) begin
            nxt_state.mains_ok = 1'b0;
        end else if (s[sps_pkg::IDX_MAINS_START]) begin
            nxt_state.mains_ok = 1'b1;
        end
        if (s[sps_pkg::IDX_RESET_LOW]) begin
            nxt_state.reset_seen_low = 1'b1;
        end
        if (s[sps_pkg::IDX_OTP]) begin
            nxt_state.otp_latched = 1'b1;
        end
        unique case (state_ff.st)
            sps_pkg::SPS_CHARGE: begin
                nxt_state.fb_running = 1'b0;
                if (s[sps_pkg::IDX_STARTUP] && !state_ff.force_stop) begin
                    nxt_state.st = sps_pkg::SPS_ARMED;
                end
            end
            sps_pkg::SPS_ARMED, sps_pkg::SPS_RUN: begin
                if (s[sps_pkg::IDX_LATCH_FAULT] || s[sps_pkg::IDX_OTP]) begin
                    nxt_state.st = sps_pkg::SPS_LATCHED;
                    nxt_state.reset_seen_low = 1'b0;
                    events[EV_LATCHED] = 1'b1;
                end else if (!s[sps_pkg::IDX_LOCKOUT]) begin
                    nxt_state.st = sps_pkg::SPS_CHARGE;
                    events[EV_LOCKOUT] = 1'b1;
                end else if (s[sps_pkg::IDX_SAFE_FAULT] || state_ff.force_stop
                             || (state_ff.fb_running && s[sps_pkg::IDX_FB_TIMEOUT])) begin
                    nxt_state.st = sps_pkg::SPS_DISCHARGE;
                    events[EV_TIMEOUT] = state_ff.fb_running && s[sps_pkg::IDX_FB_TIMEOUT];
                end else if (state_ff.st == sps_pkg::SPS_ARMED && s[sps_pkg::IDX_LATCH_EN]) begin
                    nxt_state.st = sps_pkg::SPS_RUN;
                    events[EV_RUN] = 1'b1;
                end
                if (state_ff.st == sps_pkg::SPS_RUN && s[sps_pkg::IDX_FB_SS]) begin
                    nxt_state.fb_running = 1'b1;
                end
            end
            sps_pkg::SPS_DISCHARGE: begin
                nxt_state.fb_running = 1'b0;
                if (!s[sps_pkg::IDX_LOCKOUT]) begin
                    nxt_state.st = sps_pkg::SPS_CHARGE;
                    events[EV_LOCKOUT] = 1'b1;
                end
            end
            sps_pkg::SPS_LATCHED: begin
                nxt_state.fb_running = 1'b0;
                if (state_ff.reset_seen_low && s[sps_pkg::IDX_RESET_HIGH]) begin
                    nxt_state.st = sps_pkg::SPS_CHARGE;
                    nxt_state.otp_latched = 1'b0;
                    nxt_state.reset_seen_low = 1'b0;
                end
            end
            default: nxt_state.st = sps_pkg::SPS_CHARGE;
        endcase
        // Bus access completes in one wait cycle so read data come from a flop.
        if ((i_avs_read || i_avs_write) && !state_ff.ack) begin
            nxt_state.ack = 1'b1;
            nxt_state.rdata = reg_read(i_avs_address, state_ff);
            if (i_avs_write) begin
                unique case (i_avs_address)
                    ADDR_STATUS: nxt_state.status = state_ff.status & ~i_avs_writedata[EV_W-1:0];
                    ADDR_MASK: nxt_state.mask = i_avs_writedata[EV_W-1:0];
                    ADDR_CONTROL: nxt_state.force_stop = i_avs_writedata[0];
                    default: ;
                endcase
            end
        end
        // Setting wins over a simultaneous write-one clear.
        nxt_state.status = nxt_state.status | events;
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_ff <= '{st: sps_pkg::SPS_CHARGE, default: '0};
        end else if (i_clock_enable) begin
            state_ff <= nxt_state;
        end
    end

    always_comb begin
        logic charging;
        charging = 1'b0;
        charging = state_ff.st == sps_pkg::SPS_CHARGE
                   || (state_ff.st == sps_pkg::SPS_LATCHED && !s[sps_pkg::IDX_STARTUP]);
        o_charge_on = charging && !(state_ff.st == sps_pkg::SPS_LATCHED && state_ff.otp_latched);
        o_charge_high = o_charge_on && s[sps_pkg::IDX_TRIP] && !s[sps_pkg::IDX_LOCKOUT];
    end

    assign o_internal_enable = state_ff.st == sps_pkg::SPS_ARMED || state_ff.st == sps_pkg::SPS_RUN;
    assign o_latch_source_on = o_internal_enable;
    assign o_softstart_charge = o_internal_enable;
    assign o_compensation_clamp = o_internal_enable;
    assign o_correction_drive_en = state_ff.st == sps_pkg::SPS_RUN && s[sps_pkg::IDX_COMP_EN]
                                   && s[sps_pkg::IDX_PFC_SS] && !s[sps_pkg::IDX_OVP] && state_ff.mains_ok;
    assign o_flyback_drive_en = state_ff.st == sps_pkg::SPS_RUN && state_ff.fb_running;
    assign o_irq = |(state_ff.status & state_ff.mask);
    assign o_avs_readdata = state_ff.rdata;
    assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !state_ff.ack;

    property p_latched_stays_off;
        @(posedge i_clock) disable iff (i_rst)
        state_ff.st == sps_pkg::SPS_LATCHED |-> !o_correction_drive_en && !o_flyback_drive_en;
    endproperty
    a_latched_stays_off: assert property (p_latched_stays_off) else $error("drive on while latched");
    property p_ovp_inhibit;
        @(posedge i_clock) disable iff (i_rst) s[sps_pkg::IDX_OVP] |-> !o_correction_drive_en;
    endproperty
    a_ovp_inhibit: assert property (p_ovp_inhibit) else $error("correction on during overvoltage");
    property p_charge_stops_drive;
        @(posedge i_clock) disable iff (i_rst)
        state_ff.st == sps_pkg::SPS_CHARGE |-> !o_flyback_drive_en && !o_correction_drive_en && o_charge_on;
    endproperty
    a_charge_stops_drive: assert property (p_charge_stops_drive) else $error("drive during recharge");
    property p_timeout_restart;
        @(posedge i_clock) disable iff (i_rst)
        i_clock_enable && state_ff.st == sps_pkg::SPS_RUN && state_ff.fb_running && s[sps_pkg::IDX_FB_TIMEOUT]
        && s[sps_pkg::IDX_LOCKOUT] && !s[sps_pkg::IDX_LATCH_FAULT] && !s[sps_pkg::IDX_OTP]
        |=> state_ff.st == sps_pkg::SPS_DISCHARGE && state_ff.status[EV_TIMEOUT];
    endproperty
    a_timeout_restart: assert property (p_timeout_restart) else $error("timeout did not restart");
    property p_otp_blocks_charge;
        @(posedge i_clock) disable iff (i_rst)
        state_ff.st == sps_pkg::SPS_LATCHED && state_ff.otp_latched |-> !o_charge_on;
    endproperty
    a_otp_blocks_charge: assert property (p_otp_blocks_charge) else $error("recharge during overtemperature");
    property p_running_enables;
        @(posedge i_clock) disable iff (i_rst) o_flyback_drive_en |-> o_internal_enable && !o_charge_on;
    endproperty
    a_running_enables: assert property (p_running_enables) else $error("flyback without internal enable");
    property p_irq_level;
        @(posedge i_clock) disable iff (i_rst) o_irq |-> |(state_ff.status & state_ff.mask);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt without cause");
    property p_mains_hold;
        @(posedge i_clock) disable iff (i_rst)
        !state_ff.mains_ok && !s[sps_pkg::IDX_MAINS_START] && i_clock_enable |=> !state_ff.mains_ok;
    endproperty
    a_mains_hold: assert property (p_mains_hold) else $error("mains restarted below start level");
    c_run: cover property (@(posedge i_clock) disable iff (i_rst) o_flyback_drive_en && o_correction_drive_en);
    c_latched: cover property (@(posedge i_clock) disable iff (i_rst) state_ff.st == sps_pkg::SPS_LATCHED);
    c_restart: cover property (@(posedge i_clock) disable iff (i_rst) state_ff.st == sps_pkg::SPS_DISCHARGE);
endmodule : sps_sequencer

// ===== dv/sps_analog_model.sv
// Behavioural model of the supply, protection-pin and soft-start comparators around the sequencer.
`timescale 1ns/1ns
module sps_analog_model #(
    parameter int CHARGE_CYCLES = 12
) (
    input wire logic i_clock,
    input wire logic [1:0] i_vcc_level,
    input wire logic i_latch_source_on,
    input wire logic i_latch_hold_low,
    input wire logic i_softstart_charge,
    output logic o_above_trip,
    output logic o_above_lockout,
    output logic o_above_startup,
    output logic o_latch_above_enable,
    output logic o_softstart_done
);
    int latch_cnt = 0;
    int ss_cnt = 0;
    assign o_above_trip = i_vcc_level >= 2'h1;
    assign o_above_lockout = i_vcc_level >= 2'h2;
    assign o_above_startup = i_vcc_level == 2'h3;
    assign o_latch_above_enable = latch_cnt >= CHARGE_CYCLES;
    assign o_softstart_done = ss_cnt >= CHARGE_CYCLES;
    // Pin capacitors charge slowly while their source runs and collapse at once when it stops.
    always @(posedge i_clock) begin
        latch_cnt <= (i_latch_source_on && !i_latch_hold_low) ? latch_cnt + int'(latch_cnt < CHARGE_CYCLES) : 0;
        ss_cnt <= i_softstart_charge ? ss_cnt + int'(ss_cnt < CHARGE_CYCLES) : 0;
    end
endmodule : sps_analog_model

// ===== dv/sps_testbench.sv
// Self-checking testbench for the start-up protection sequencer.
`timescale 1ns/1ns
module testbench;
    typedef struct {logic [31:0] exp; logic [31:0] mask;} sps_tb_note_s;
    sps_tb_note_s notes[$];
    sps_tb_note_s nt;
    int fail_count = 0;
    int n_tests = 0;
    int cycles = 0;
    logic i_clock = 1'h0;
    logic i_rst = 1'h1;
    logic ce = 1'h1;
    logic [1:0] vcc = 2'h0;
    logic hold_low = 1'h0, comp = 1'h0, fb_gate = 1'h0, fbto = 1'h0, overvoltage_protection = 1'h0, mstop = 1'h0;
    logic mstart = 1'h0, rlow = 1'h0, rhigh = 1'h0, otp = 1'h0, sfault = 1'h0, lfault = 1'h0;
    logic [1:0] i_avs_address = 2'h0;
    logic i_avs_read = 1'h0, i_avs_write = 1'h0;
    logic [31:0] i_avs_writedata = 32'h0;
    logic [31:0] o_avs_readdata;
    logic o_avs_waitrequest, o_charge_on, o_charge_high, o_internal_enable, o_latch_source_on;
    logic o_softstart_charge, o_compensation_clamp, o_correction_drive_en, o_flyback_drive_en, o_irq;
    logic trip, lockout, startup, latch_en, ss_done;
    initial forever #20 i_clock = ~i_clock;
    sps_analog_model i_sps_analog_model (.i_clock(i_clock), .i_vcc_level(vcc), .i_latch_source_on(o_latch_source_on),
        .i_latch_hold_low(hold_low), .i_softstart_charge(o_softstart_charge), .o_above_trip(trip),
        .o_above_lockout(lockout), .o_above_startup(startup), .o_latch_above_enable(latch_en),
        .o_softstart_done(ss_done));
    sps_sequencer i_sps_sequencer (.i_clock(i_clock), .i_rst(i_rst), .i_clock_enable(ce),
        .i_supply_above_trip(trip), .i_supply_above_lockout(lockout), .i_supply_above_startup(startup),
        .i_latch_above_enable(latch_en), .i_compensation_at_enable(comp), .i_correction_softstart_done(ss_done),
        .i_flyback_softstart_done(ss_done & fb_gate), .i_feedback_at_timeout(fbto), .i_correction_overvoltage(overvoltage_protection),
        .i_mains_below_stop(mstop), .i_mains_above_start(mstart), .i_mains_below_reset_low(rlow),
        .i_mains_above_reset_high(rhigh), .i_overtemperature(otp), .i_safe_restart_fault(sfault),
        .i_latched_fault(lfault), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
        .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest), .o_charge_on(o_charge_on), .o_charge_high(o_charge_high),
        .o_internal_enable(o_internal_enable), .o_latch_source_on(o_latch_source_on),
        .o_softstart_charge(o_softstart_charge), .o_compensation_clamp(o_compensation_clamp),
        .o_correction_drive_en(o_correction_drive_en), .o_flyback_drive_en(o_flyback_drive_en), .o_irq(o_irq));
    task automatic print_verdict();
        if (fail_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
    task automatic chk(input string name, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic wait_n(input int n);
        repeat (n) @(negedge i_clock);
    endtask : wait_n
    // The request is held until an edge that sees waitrequest low, then released on the next edge.
    task automatic bus(input logic wr, input logic [1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clock);
        i_avs_address <= a;
        i_avs_write <= wr;
        i_avs_read <= !wr;
        i_avs_writedata <= d;
        do begin
            @(negedge i_clock);
            n++;
        end while (o_avs_waitrequest !== 1'h0 && n < 50);
        if (n >= 50)
            fail_count++;
        @(posedge i_clock);
        i_avs_read <= 1'h0;
        i_avs_write <= 1'h0;
    endtask : bus
    task automatic rd(input logic [1:0] a, input logic [31:0] exp, input logic [31:0] mask);
        notes.push_back('{exp, mask});
        bus(1'h0, a, $urandom());
    endtask : rd
    task automatic lvl(input logic [1:0] v);
        @(posedge i_clock);
        vcc <= v;
        wait_n(5);
    endtask : lvl
    // Read data stand from the acknowledging edge, so the settled value is compared mid-cycle.
    always @(negedge i_clock) begin
        if (i_avs_read && o_avs_waitrequest === 1'h0 && notes.size() > 0) begin
            nt = notes.pop_front();
            n_tests++;
            if ((o_avs_readdata & nt.mask) !== nt.exp) begin
                fail_count++;
                $display("ERROR readdata expected %h seen %h", nt.exp, o_avs_readdata & nt.mask);
            end
        end
    end
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 6000) begin
            fail_count++;
            print_verdict();
        end
    end
    initial begin
        void'($urandom(32'h33d4));
        repeat (6) @(posedge i_clock);
        i_rst <= 1'h0;
        wait_n(4);
        chk("charge_on", 1'h1, o_charge_on);
        chk("charge_high", 1'h0, o_charge_high);
        rd(2'h1, 32'h0, 32'hf);
        @(posedge i_clock);
        vcc <= 2'h1;
        wait_n(2);
        chk("charge_high", 1'h0, o_charge_high);
        wait_n(3);
        chk("charge_high", 1'h1, o_charge_high);
        lvl(2'h2);
        chk("charge_high", 1'h0, o_charge_high);
        chk("charge_on", 1'h1, o_charge_on);
        lvl(2'h3);
        chk("internal_enable", 1'h1, o_internal_enable);
        chk("charge_on", 1'h0, o_charge_on);
        chk("latch_source_on", 1'h1, o_latch_source_on);
        chk("softstart_charge", 1'h1, o_softstart_charge);
        chk("compensation_clamp", 1'h1, o_compensation_clamp);
        rd(2'h2, 32'h1, 32'h7);
        mstart <= 1'h1;
        wait_n(30);
        chk("correction_drive", 1'h0, o_correction_drive_en);
        chk("flyback_drive", 1'h0, o_flyback_drive_en);
        @(posedge i_clock);
        comp <= 1'h1;
        wait_n(5);
        chk("correction_drive", 1'h1, o_correction_drive_en);
        @(posedge i_clock);
        fb_gate <= 1'h1;
        wait_n(5);
        chk("flyback_drive", 1'h1, o_flyback_drive_en);
        @(posedge i_clock);
        overvoltage_protection <= 1'h1;
        wait_n(5);
        chk("correction_drive", 1'h0, o_correction_drive_en);
        chk("flyback_drive", 1'h1, o_flyback_drive_en);
        @(posedge i_clock);
        overvoltage_protection <= 1'h0;
        wait_n(5);
        chk("correction_drive", 1'h1, o_correction_drive_en);
        @(posedge i_clock);
        mstart <= 1'h0;
        mstop <= 1'h1;
        wait_n(5);
        chk("correction_drive", 1'h0, o_correction_drive_en);
        @(posedge i_clock);
        mstop <= 1'h0;
        wait_n(5);
        chk("correction_drive", 1'h0, o_correction_drive_en);
        @(posedge i_clock);
        mstart <= 1'h1;
        wait_n(5);
        chk("correction_drive", 1'h1, o_correction_drive_en);
        bus(1'h1, 2'h1, 32'h1);
        // Feedback timeout, a safe-restart fault and the forced stop each take the restart path.
        for (int k = 0; k < 3; k++) begin
            repeat ($urandom_range(1, 8)) @(posedge i_clock);
            if (k == 2)
                bus(1'h1, 2'h3, 32'h1);
            fbto <= k == 0;
            sfault <= k == 1;
            wait_n(5);
            chk("correction_drive", 1'h0, o_correction_drive_en);
            chk("flyback_drive", 1'h0, o_flyback_drive_en);
            rd(2'h2, 32'h3, 32'h7);
            if (k == 0)
                rd(2'h0, 32'h9, 32'h9);
            fbto <= 1'h0;
            sfault <= 1'h0;
            bus(1'h1, 2'h3, 32'h0);
            if (k == 0)
                chk("irq", 1'h1, o_irq);
            bus(1'h1, 2'h0, 32'h1);
            wait_n(1);
            chk("irq", 1'h0, o_irq);
            lvl(2'h1);
            chk("charge_on", 1'h1, o_charge_on);
            rd(2'h2, 32'h0, 32'h7);
            lvl(2'h3);
            wait_n(40);
            chk("correction_drive", 1'h1, o_correction_drive_en);
            chk("flyback_drive", 1'h1, o_flyback_drive_en);
        end
        lvl(2'h1);
        @(posedge i_clock);
        hold_low <= 1'h1;
        lvl(2'h3);
        wait_n(30);
        chk("correction_drive", 1'h0, o_correction_drive_en);
        lvl(2'h1);
        chk("internal_enable", 1'h0, o_internal_enable);
        chk("charge_on", 1'h1, o_charge_on);
        @(posedge i_clock);
        hold_low <= 1'h0;
        lvl(2'h3);
        wait_n(40);
        @(posedge i_clock);
        lfault <= 1'h1;
        wait_n(5);
        chk("flyback_drive", 1'h0, o_flyback_drive_en);
        rd(2'h2, 32'h4, 32'h7);
        lfault <= 1'h0;
        lvl(2'h2);
        chk("charge_on", 1'h1, o_charge_on);
        lvl(2'h3);
        wait_n(40);
        chk("flyback_drive", 1'h0, o_flyback_drive_en);
        @(posedge i_clock);
        otp <= 1'h1;
        lvl(2'h2);
        chk("charge_on", 1'h0, o_charge_on);
        rd(2'h2, 32'h84, 32'h87);
        otp <= 1'h0;
        lvl(2'h1);
        @(posedge i_clock);
        rlow <= 1'h1;
        wait_n(5);
        @(posedge i_clock);
        rlow <= 1'h0;
        rhigh <= 1'h1;
        wait_n(5);
        rd(2'h2, 32'h0, 32'h87);
        // With the clock enable low the start-up threshold must not be acted on.
        @(posedge i_clock);
        ce <= 1'h0;
        lvl(2'h3);
        chk("internal_enable", 1'h0, o_internal_enable);
        @(posedge i_clock);
        ce <= 1'h1;
        wait_n(5);
        chk("internal_enable", 1'h1, o_internal_enable);
        wait_n(4);
        print_verdict();
    end
endmodule : testbench
